// ===== float_control_status_reg.sv
`timescale 1ns/100ps
`default_nettype none
module float_control_status_reg
    import float_csr_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire fp_event_t   fp_event,
    output fp_trap_t         fp_trap,
    output round_mode_t      dynamic_rounding_select,
    output logic             irq
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [5:0]  flags_reg;
    logic        imprecise_trap_disable_reg;
    logic        underflow_trap_disable_reg;
    logic        underflow_flush_zero_reg;
    logic [1:0]  rounding_reg;
    logic        overflow_trap_disable_reg;
    logic        zero_divide_trap_disable_reg;
    logic        bad_operand_trap_disable_reg;
    logic        denormal_as_zero_reg;
    logic [5:0]  irq_stat_reg;
    logic [5:0]  irq_mask_reg;
    logic [63:0] fcs_view;
    logic        summary;

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [3:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_fire;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg  <= 32'h0;
            wstrb_reg  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    logic wr_known;
    assign wr_known = awaddr_reg[3:2] inside {ADDR_FCS_LO[3:2], ADDR_FCS_HI[3:2],
                                              ADDR_IRQ_STAT[3:2], ADDR_IRQ_MASK[3:2]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_known && awaddr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // high word of the register is written lane by lane, bytes 3 and 2 each under its own strobe; status and mask need lane 0
    logic        wr_hi;
    logic        wr_stat;
    logic        wr_mask;
    logic [31:0] wd;
    assign wd      = wdata_reg;
    assign wr_hi   = wr_fire && awaddr_reg == ADDR_FCS_HI;
    assign wr_stat = wr_fire && awaddr_reg == ADDR_IRQ_STAT && wstrb_reg[0];
    assign wr_mask = wr_fire && awaddr_reg == ADDR_IRQ_MASK && wstrb_reg[0];

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imprecise_trap_disable_reg   <= 1'b0;
            underflow_trap_disable_reg   <= 1'b0;
            underflow_flush_zero_reg     <= 1'b0;
            rounding_reg                 <= RM_RESET;
            overflow_trap_disable_reg    <= 1'b0;
            zero_divide_trap_disable_reg <= 1'b0;
            bad_operand_trap_disable_reg <= 1'b0;
            denormal_as_zero_reg         <= 1'b0;
        end else if (wr_hi) begin
            if (wstrb_reg[3]) begin
                imprecise_trap_disable_reg <= wd[BIT_INEXACT_DIS - 32];
                underflow_trap_disable_reg <= wd[BIT_UNDER_DIS - 32];
                underflow_flush_zero_reg   <= wd[BIT_FLUSH_ZERO - 32];
                rounding_reg               <= wd[BIT_RM_HI - 32:BIT_RM_LO - 32];
            end
            if (wstrb_reg[2]) begin
                overflow_trap_disable_reg    <= wd[BIT_OVER_DIS - 32];
                zero_divide_trap_disable_reg <= wd[BIT_ZDIV_DIS - 32];
                bad_operand_trap_disable_reg <= wd[BIT_BADOP_DIS - 32];
                denormal_as_zero_reg         <= wd[BIT_DENORM_ZERO - 32];
            end
        end
    end

    assign dynamic_rounding_select = round_mode_t'(rounding_reg);

    // ------------------------------------------------------------
    // sticky exception flags
    // ------------------------------------------------------------
    logic [5:0] flags_next;
    logic [5:0] raised;
    logic [5:0] wr_flags;
    logic [5:0] wr_lanes;
    assign raised = fp_event.valid ? fp_event.raised : 6'h00;
    // flags 57..56 sit in byte 3, 55..52 in byte 2
    assign wr_flags = wd[BIT_FLAG_HI - 32:BIT_FLAG_LO - 32];
    assign wr_lanes = {{2{wstrb_reg[3]}}, {4{wstrb_reg[2]}}};

    generate
        for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
            // set wins over a software clear in the same cycle
            always_comb begin
                flags_next[i] = flags_reg[i];
                if (wr_hi && wr_lanes[i]) begin
                    flags_next[i] = wr_flags[i];
                end
                if (raised[i]) begin
                    flags_next[i] = 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_reg <= FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign summary = |flags_reg;

    always_comb begin
        fcs_view                         = ZERO64;
        fcs_view[BIT_SUMMARY]            = summary;
        fcs_view[BIT_INEXACT_DIS]        = imprecise_trap_disable_reg;
        fcs_view[BIT_UNDER_DIS]          = underflow_trap_disable_reg;
        fcs_view[BIT_FLUSH_ZERO]         = underflow_flush_zero_reg;
        fcs_view[BIT_RM_HI:BIT_RM_LO]    = rounding_reg;
        fcs_view[BIT_FLAG_HI:BIT_FLAG_LO] = flags_reg;
        fcs_view[BIT_OVER_DIS]           = overflow_trap_disable_reg;
        fcs_view[BIT_ZDIV_DIS]           = zero_divide_trap_disable_reg;
        fcs_view[BIT_BADOP_DIS]          = bad_operand_trap_disable_reg;
        fcs_view[BIT_DENORM_ZERO]        = denormal_as_zero_reg;
    end

    // ------------------------------------------------------------
    // trap decision
    // ------------------------------------------------------------
    fp_trap_t trap_next;
    logic     denorm_zero_active;
    logic     under_suppress;
    always_comb begin
        denorm_zero_active = denormal_as_zero_reg && fp_event.sw_complete;
        under_suppress     = underflow_trap_disable_reg && underflow_flush_zero_reg
                             && fp_event.sw_complete;
        trap_next                = '0;
        trap_next.trap_cause     = raised;
        trap_next.denorm_to_zero = fp_event.valid && fp_event.denorm_input
                                   && denorm_zero_active;
        if (imprecise_trap_disable_reg) begin
            trap_next.trap_cause[FL_INEXACT] = 1'b0;
        end
        if (under_suppress) begin
            trap_next.trap_cause[FL_UNDER] = 1'b0;
        end
        if (zero_divide_trap_disable_reg) begin
            trap_next.trap_cause[FL_ZDIV] = 1'b0;
        end
        if (bad_operand_trap_disable_reg) begin
            trap_next.trap_cause[FL_BADOP] = 1'b0;
        end
        if (fp_event.valid && fp_event.denorm_input) begin
            if (!fp_event.sw_complete) begin
                trap_next.trap_cause[FL_BADOP] = 1'b1;
            end else if (denorm_zero_active) begin
                trap_next.trap_cause[FL_BADOP] = 1'b0;
            end
        end
        trap_next.zero_result = fp_event.valid && raised[FL_UNDER]
                                && underflow_trap_disable_reg
                                && underflow_flush_zero_reg;
        trap_next.trap = |trap_next.trap_cause;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fp_trap <= '0;
        end else begin
            fp_trap <= trap_next;
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= 6'h00;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? wd[5:0] : 6'h00)) | raised;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_reg <= 6'h00;
        end else if (wr_mask) begin
            irq_mask_reg <= wd[5:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_FCS_LO: begin
                    s_axi_rdata <= fcs_view[31:0];
                end
                ADDR_FCS_HI: begin
                    s_axi_rdata <= fcs_view[63:32];
                end
                ADDR_IRQ_STAT: begin
                    s_axi_rdata <= {26'h0, irq_stat_reg};
                end
                ADDR_IRQ_MASK: begin
                    s_axi_rdata <= {26'h0, irq_mask_reg};
                end
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_summary_or: assert property (@(posedge aclk) disable iff (!aresetn)
        fcs_view[BIT_SUMMARY] == |fcs_view[BIT_FLAG_HI:BIT_FLAG_LO])
        else $error("summary bit differs from flag or");
    a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && $past(s_axi_araddr) == ADDR_FCS_LO && $rose(s_axi_rvalid)
        |-> s_axi_rdata == 32'h0)
        else $error("reserved bits read nonzero");
    a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        flags_reg[FL_OVER] && !wr_hi |=> flags_reg[FL_OVER])
        else $error("flag cleared without a write");
    a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        fp_event.valid && fp_event.raised[FL_OVER] |=> flags_reg[FL_OVER])
        else $error("overflow flag not set");
    a_iov_set: assert property (@(posedge aclk) disable iff (!aresetn)
        fp_event.valid && fp_event.raised[FL_INTOVER] |=> fcs_view[BIT_FLAG_HI] && summary)
        else $error("integer overflow flag not set");
    a_ine_masked: assert property (@(posedge aclk) disable iff (!aresetn)
        imprecise_trap_disable_reg |=> !fp_trap.trap_cause[FL_INEXACT])
        else $error("inexact trap not suppressed");
    a_unf_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        fp_event.valid && fp_event.raised[FL_UNDER] && underflow_trap_disable_reg
        && underflow_flush_zero_reg |=> fp_trap.zero_result)
        else $error("flush to zero not signalled");
    a_unf_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        fp_event.valid && fp_event.raised[FL_UNDER] && !(underflow_trap_disable_reg
        && underflow_flush_zero_reg && fp_event.sw_complete) |=> fp_trap.trap_cause[FL_UNDER])
        else $error("underflow trap wrongly suppressed");
    a_dze_masked: assert property (@(posedge aclk) disable iff (!aresetn)
        zero_divide_trap_disable_reg |=> !fp_trap.trap_cause[FL_ZDIV])
        else $error("divide by zero trap not suppressed");
    a_inv_masked: assert property (@(posedge aclk) disable iff (!aresetn)
        bad_operand_trap_disable_reg
        && !(fp_event.valid && fp_event.denorm_input && !fp_event.sw_complete)
        |=> !fp_trap.trap_cause[FL_BADOP])
        else $error("invalid operation trap not suppressed");
    a_ovf_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        fp_event.valid && fp_event.raised[FL_OVER] |=> fp_trap.trap_cause[FL_OVER])
        else $error("overflow trap suppressed");
    a_dnz_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        fp_event.valid && fp_event.denorm_input && fp_event.sw_complete
        && denormal_as_zero_reg |=> fp_trap.denorm_to_zero && !fp_trap.trap_cause[FL_BADOP])
        else $error("denormal not treated as zero");
    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
    a_denorm_trap: assert property (@(posedge aclk) disable iff (!aresetn)
        fp_event.valid && fp_event.denorm_input && !fp_event.sw_complete
        |=> fp_trap.trap && fp_trap.trap_cause[FL_BADOP])
        else $error("denormal without qualifier did not trap");
    a_rm_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_hi && wstrb_reg[3] |=> dynamic_rounding_select == $past(wd[27:26]))
        else $error("rounding mode not written");

endmodule
`default_nettype wire

// ===== float_control_status_pkg.sv
`default_nettype none
package float_csr_pkg;

    // register map (byte addresses)
    localparam logic [3:0] ADDR_FCS_LO   = 4'h0;
    localparam logic [3:0] ADDR_FCS_HI   = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

    // bit positions within the 64-bit register
    localparam int BIT_SUMMARY = 63;
    localparam int BIT_INEXACT_DIS = 62;
    localparam int BIT_UNDER_DIS   = 61;
    localparam int BIT_FLUSH_ZERO  = 60;
    localparam int BIT_RM_HI   = 59;
    localparam int BIT_RM_LO   = 58;
    localparam int BIT_FLAG_HI = 57;
    localparam int BIT_FLAG_LO = 52;
    localparam int BIT_OVER_DIS    = 51;
    localparam int BIT_ZDIV_DIS    = 50;
    localparam int BIT_BADOP_DIS   = 49;
    localparam int BIT_DENORM_ZERO = 48;
    localparam int NUM_FLAGS   = 6;

    // flag index within the six-bit flag vector
    localparam int FL_BADOP   = 0;
    localparam int FL_ZDIV    = 1;
    localparam int FL_OVER    = 2;
    localparam int FL_UNDER   = 3;
    localparam int FL_INEXACT = 4;
    localparam int FL_INTOVER = 5;

    localparam logic [5:0]  FLAGS_RESET = 6'h00;
    localparam logic [1:0]  RM_RESET    = 2'h2;
    localparam logic [63:0] ZERO64      = 64'h0;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RM_CHOPPED = 2'h0,
        RM_MINUS   = 2'h1,
        RM_NORMAL  = 2'h2,
        RM_PLUS    = 2'h3
    } round_mode_t;

    // per-operation exception report from the datapath
    typedef struct packed {
        logic       valid;
        logic       sw_complete;
        logic       denorm_input;
        logic [5:0] raised;
    } fp_event_t;

    // trap decision back to the datapath
    typedef struct packed {
        logic       trap;
        logic       zero_result;
        logic       denorm_to_zero;
        logic [5:0] trap_cause;
    } fp_trap_t;

endpackage
`default_nettype wire

// ===== float_control_status_reg_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module float_control_status_reg_tb_top import float_csr_pkg::*;;
    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    fp_event_t   fp_event = '0;
    fp_trap_t    fp_trap;
    round_mode_t dynamic_rounding_select;
    logic        irq;
    int          error_cnt = 0;
    int          num_checks = 0;

    always #10 aclk = ~aclk;

    float_control_status_reg dut_u (
        .aclk                    (aclk),
        .aresetn                 (aresetn),
        .s_axi_awaddr            (s_axi_awaddr),
        .s_axi_awvalid           (s_axi_awvalid),
        .s_axi_awready           (s_axi_awready),
        .s_axi_wdata             (s_axi_wdata),
        .s_axi_wstrb             (s_axi_wstrb),
        .s_axi_wvalid            (s_axi_wvalid),
        .s_axi_wready            (s_axi_wready),
        .s_axi_bresp             (s_axi_bresp),
        .s_axi_bvalid            (s_axi_bvalid),
        .s_axi_bready            (s_axi_bready),
        .s_axi_araddr            (s_axi_araddr),
        .s_axi_arvalid           (s_axi_arvalid),
        .s_axi_arready           (s_axi_arready),
        .s_axi_rdata             (s_axi_rdata),
        .s_axi_rresp             (s_axi_rresp),
        .s_axi_rvalid            (s_axi_rvalid),
        .s_axi_rready            (s_axi_rready),
        .fp_event                (fp_event),
        .fp_trap                 (fp_trap),
        .dynamic_rounding_select (dynamic_rounding_select),
        .irq                     (irq)
    );

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic hang();
        error_cnt++;
        $display("BAD handshake expected answer seen none");
        final_report();
    endtask

    // ------------------------------------------------------------
    // bus and datapath access
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int   n;
        logic done;
        n    = 0;
        done = 1'b0;
        r    = RESP_SLVERR;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!done && n < 50) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) hang();
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic done;
        n    = 0;
        done = 1'b0;
        d    = 32'h0;
        r    = RESP_SLVERR;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!done && n < 50) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) hang();
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        check("write response", 32'(r), 32'(RESP_OKAY));
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check(what, d, exp);
        check("read response", 32'(r), 32'(RESP_OKAY));
    endtask

    // one datapath report, then the trap answer in the following cycle
    task automatic ev(input logic sw, input logic dn, input logic [5:0] rs,
                      input logic [5:0] cause, input logic zr, input logic dz);
        @(posedge aclk);
        fp_event <= '{valid: 1'b1, sw_complete: sw, denorm_input: dn, raised: rs};
        @(posedge aclk);
        fp_event <= '0;
        #1;
        check("trap cause", 32'(fp_trap.trap_cause), 32'(cause));
        check("trap", 32'(fp_trap.trap), 32'(|cause));
        check("zero result", 32'(fp_trap.zero_result), 32'(zr));
        check("denormal to zero", 32'(fp_trap.denorm_to_zero), 32'(dz));
    endtask

    task automatic tcase(input logic [31:0] ctl, input logic sw, input logic dn,
                         input logic [5:0] rs, input logic [5:0] cause,
                         input logic zr, input logic dz);
        wr(4'h4, ctl);
        ev(sw, dn, rs, cause, zr, dz);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] exp;
        logic [31:0] d;
        logic [1:0]  r;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 32'h0, "low word");
        rd(4'h4, 32'h0800_0000, "high word");
        rd(4'h8, 32'h0, "irq status");
        rd(4'hc, 32'h0, "irq mask");
        check("rounding select", 32'(dynamic_rounding_select), 32'(RM_NORMAL));
        check("irq at reset", 32'(irq), 32'h0);
        $display("test reset done");
        wr(4'h0, 32'hffff_ffff);
        rd(4'h0, 32'h0, "low word written");
        wr(4'h4, 32'h8000_0000);
        rd(4'h4, 32'h0, "summary written alone");
        for (int i = 0; i < 4; i++) begin
            wr(4'h4, 32'(i) << 26);
            rd(4'h4, 32'(i) << 26, "rounding field");
            check("rounding select", 32'(dynamic_rounding_select), 32'(i));
        end
        $display("test fields done");
        wr(4'h4, 32'h0);
        exp = 32'h8000_0000;
        for (int i = 0; i < 6; i++) begin
            ev(1'b0, 1'b0, 6'(1 << i), 6'(1 << i), 1'b0, 1'b0);
            exp = exp | (32'h1 << (20 + i));
            rd(4'h4, exp, "sticky flags");
        end
        wr(4'h4, 32'h0200_0000);
        rd(4'h4, 32'h8200_0000, "flags partly cleared");
        wr(4'h4, 32'h0);
        rd(4'h4, 32'h0, "flags cleared");
        $display("test flags done");
        tcase(32'h4000_0000, 1'b0, 1'b0, 6'h10, 6'h00, 1'b0, 1'b0);
        tcase(32'h0000_0000, 1'b0, 1'b0, 6'h10, 6'h10, 1'b0, 1'b0);
        tcase(32'h3000_0000, 1'b1, 1'b0, 6'h08, 6'h00, 1'b1, 1'b0);
        tcase(32'h3000_0000, 1'b0, 1'b0, 6'h08, 6'h08, 1'b1, 1'b0);
        tcase(32'h2000_0000, 1'b1, 1'b0, 6'h08, 6'h08, 1'b0, 1'b0);
        tcase(32'h0004_0000, 1'b0, 1'b0, 6'h02, 6'h00, 1'b0, 1'b0);
        tcase(32'h0002_0000, 1'b0, 1'b0, 6'h01, 6'h00, 1'b0, 1'b0);
        tcase(32'h0008_0000, 1'b0, 1'b0, 6'h04, 6'h04, 1'b0, 1'b0);
        tcase(32'h0001_0000, 1'b1, 1'b1, 6'h00, 6'h00, 1'b0, 1'b1);
        tcase(32'h0001_0000, 1'b0, 1'b1, 6'h00, 6'h01, 1'b0, 1'b0);
        $display("test traps done");
        wr(4'h8, 32'h0000_003f);
        wr(4'hc, 32'h0);
        ev(1'b0, 1'b0, 6'h04, 6'h04, 1'b0, 1'b0);
        rd(4'h8, 32'h0000_0004, "irq status set");
        check("irq masked", 32'(irq), 32'h0);
        wr(4'hc, 32'h0000_0004);
        check("irq unmasked", 32'(irq), 32'h1);
        wr(4'h8, 32'h0000_0004);
        check("irq cleared", 32'(irq), 32'h0);
        rd(4'h8, 32'h0, "irq status cleared");
        $display("test interrupt done");
        axi_wr(4'h2, 32'hffff_ffff, r);
        check("unaligned write response", 32'(r), 32'(RESP_SLVERR));
        axi_rd(4'h2, d, r);
        check("unaligned read data", d, 32'h0);
        check("unaligned read response", 32'(r), 32'(RESP_SLVERR));
        rd(4'h4, 32'h8041_0000, "high word untouched");
        $display("test unmapped done");
        final_report();
    end
endmodule
`default_nettype wire
